//--- src/shadow_ram_consts.vh
/*
  Timing constants for the shadow RAM host controller.
  Assumes a 40 MHz controller clock; times are given in ns.
*/
`ifndef SHADOW_RAM_CONSTS_VH
`define SHADOW_RAM_CONSTS_VH

`define CLK_PERIOD_NS           25
// Store pulse: least time, rounded up
`define STORE_PULSE_MIN_NS      100
`define STORE_PULSE_CYC         ((`STORE_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Output strobe off before store begins: least time
`define OUTPUT_OFF_BEFORE_STORE_NS 20
`define OUTPUT_OFF_CYC          ((`OUTPUT_OFF_BEFORE_STORE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Recall pulse window 0.1 .. 1 us; aim low end, never above top
`define RECALL_PULSE_MIN_NS     100
`define RECALL_PULSE_MAX_NS     1000
`define RECALL_PULSE_CYC        ((`RECALL_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECALL_PULSE_MAX_CYC    (`RECALL_PULSE_MAX_NS / `CLK_PERIOD_NS)
// Recall duration: wait before next access
`define RECALL_DURATION_NS      5000
`define RECALL_DURATION_CYC     (`RECALL_DURATION_NS / `CLK_PERIOD_NS)
// Store cycle time 5 ms
`define STORE_CYCLE_NS          5000000
`define STORE_CYCLE_CYC         (`STORE_CYCLE_NS / `CLK_PERIOD_NS)
// Write: chip select low width and write pulse width
`define WRITE_CS_MIN_NS         150
`define WRITE_CS_CYC            ((`WRITE_CS_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Output active from end of write, and release after strobes
`define OUTPUT_ACTIVE_MIN_NS    5
`define OUTPUT_ACTIVE_CYC       1
// Power-up waits
`define POWERUP_RAM_NS          100000
`define POWERUP_RAM_CYC         (`POWERUP_RAM_NS / `CLK_PERIOD_NS)
`define POWERUP_NV_NS           5000000
`define POWERUP_NV_CYC          (`POWERUP_NV_NS / `CLK_PERIOD_NS)
// Request codes
`define OP_WRITE                2'h0
`define OP_READ                 2'h1
`define OP_STORE                2'h2
`define OP_RECALL               2'h3

`endif

//--- src/shadow_ram_host.v
/*
  Host controller that sequences a byte-wide shadowed static RAM:
  RAM write, RAM read, store (RAM to nonvolatile) and recall.
  Assumes the memory is wired straight to the pin ports, and that the
  user side holds req until it is taken.
*/
// Function
// - store holds nv, write, select low 100ns
// - output strobe high 20ns before store
// - recall holds nv, output, select 0.1-1us
// - write keeps select low 150ns
`timescale 1ns/1ps
`include "shadow_ram_consts.vh"
module shadow_ram_host #(
  parameter AW             = 9,
  parameter DW             = 8,
  parameter TW             = 24,
  parameter POWERUP_RAM    = `POWERUP_RAM_CYC,
  parameter POWERUP_NV     = `POWERUP_NV_CYC,
  parameter STORE_CYCLE    = `STORE_CYCLE_CYC
) (
  input  wire          clk,                  // 40 MHz clock
  input  wire          srst,                 // Sync reset, high
  input  wire          ce,                   // Clock enable
  input  wire          req,                  // Request, held until taken
  input  wire [1:0]    op,                   // Request code
  input  wire [AW-1:0] addr,                 // RAM address
  input  wire [DW-1:0] wdata,                // Write data
  output wire          ready,                // Idle, may take req
  output reg           ack,                  // One-cycle done pulse
  output reg  [DW-1:0] rdata,                // Read data
  output reg           ram_ready,            // RAM access allowed
  output reg           nv_ready,             // Store/recall allowed
  output reg  [AW-1:0] mem_addr,             // Address pins
  output reg           chip_select_n,        // Chip select, low
  output reg           write_strobe_n,       // Write strobe, low
  output reg           output_strobe_n,      // Output drive, low
  output reg           nonvolatile_strobe_n, // Nonvolatile strobe, low
  input  wire [DW-1:0] data_in,              // Data pins in
  output reg  [DW-1:0] data_out,             // Data pins out
  output reg           data_oe               // Data drive enable
);
  // --------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_WR   = 7'h02;
  localparam [6:0] S_RD   = 7'h04;
  localparam [6:0] S_SOFF = 7'h08;
  localparam [6:0] S_STP  = 7'h10;
  localparam [6:0] S_RCP  = 7'h20;
  localparam [6:0] S_BUSY = 7'h40;

  reg  [6:0]    state;
  reg  [6:0]    next_state;
  reg  [DW-1:0] din_meta;
  reg  [DW-1:0] din_sync;
  reg           t_load;
  reg  [TW-1:0] t_count;
  wire          t_done;
  reg  [TW-1:0] pu_cnt;

  // Phase lengths in cycles; cut to the timer width where used
  localparam WR_CYC  = `WRITE_CS_CYC;
  localparam RD_CYC  = `WRITE_CS_CYC + 2;
  localparam OFF_CYC = `OUTPUT_OFF_CYC;
  localparam STP_CYC = `STORE_PULSE_CYC;
  localparam RCP_CYC = `RECALL_PULSE_CYC;
  localparam RCC_CYC = `RECALL_DURATION_CYC;
  localparam REC_CYC = `OUTPUT_ACTIVE_CYC;

  // Ops that touch the nonvolatile array
  function is_nv;
    input [1:0] o;
    begin
      is_nv = (o == `OP_STORE) || (o == `OP_RECALL);
    end
  endfunction

  // Requests only while idle, and only after the matching power-up wait
  assign ready = (state == S_IDLE) && ram_ready && (!is_nv(op) || nv_ready);

  // --------------------------------------------------------------------
  // Phase timer
  // --------------------------------------------------------------------
  wait_timer #(.W(TW)) u_timer (
    .clk   (clk),
    .srst  (srst),
    .ce    (ce),
    .load  (t_load),
    .count (t_count),
    .busy  (),
    .done  (t_done)
  );

  // Power-up counter; the device needs time before any access
  always @(posedge clk) begin
    if (srst) begin
      pu_cnt    <= {TW{1'b0}};
      ram_ready <= 1'b0;
      nv_ready  <= 1'b0;
    end else if (ce) begin
      if (!nv_ready)
        pu_cnt <= pu_cnt + {{(TW-1){1'b0}}, 1'b1};
      if (pu_cnt >= POWERUP_RAM[TW-1:0])
        ram_ready <= 1'b1;
      if (pu_cnt >= POWERUP_NV[TW-1:0])
        nv_ready <= 1'b1;
    end
  end

  // Two-flop sync of data pins before capture
  always @(posedge clk) begin
    if (srst) begin
      din_meta <= {DW{1'b0}};
      din_sync <= {DW{1'b0}};
    end else if (ce) begin
      din_meta <= data_in;
      din_sync <= din_meta;
    end
  end

  // --------------------------------------------------------------------
  // Next state and phase loads
  // --------------------------------------------------------------------
  always @* begin
    next_state = state;
    t_load     = 1'b0;
    t_count    = {TW{1'b0}};
    case (state)
      S_IDLE: begin
        if (req && ready) begin
          t_load = 1'b1;
          case (op)
            `OP_WRITE: begin
              next_state = S_WR;
              t_count = WR_CYC[TW-1:0];
            end
            `OP_READ: begin
              next_state = S_RD;
              t_count = RD_CYC[TW-1:0];             // Access plus sync delay
            end
            `OP_STORE: begin
              next_state = S_SOFF;
              t_count = OFF_CYC[TW-1:0];
            end
            default: begin
              next_state = S_RCP;
              t_count = RCP_CYC[TW-1:0];
            end
          endcase
        end
      end
      S_WR, S_RD: if (t_done) begin
        next_state = S_BUSY;
        t_load     = 1'b1;
        t_count    = REC_CYC[TW-1:0];
      end
      S_SOFF: if (t_done) begin
        next_state = S_STP;
        t_load     = 1'b1;
        t_count    = STP_CYC[TW-1:0];
      end
      S_STP: if (t_done) begin
        next_state = S_BUSY;
        t_load     = 1'b1;
        t_count    = STORE_CYCLE[TW-1:0];
      end
      S_RCP: if (t_done) begin
        next_state = S_BUSY;
        t_load     = 1'b1;
        t_count    = RCC_CYC[TW-1:0];
      end
      S_BUSY: if (t_done)
        next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  // --------------------------------------------------------------------
  // State, pins and answer, all registered
  // --------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      state                <= S_IDLE;
      ack                  <= 1'b0;
      rdata                <= {DW{1'b0}};
      mem_addr             <= {AW{1'b0}};
      chip_select_n        <= 1'b1;
      write_strobe_n       <= 1'b1;
      output_strobe_n      <= 1'b1;
      nonvolatile_strobe_n <= 1'b1;
      data_out             <= {DW{1'b0}};
      data_oe              <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      ack   <= 1'b0;
      // Default: all strobes idle, bus released
      chip_select_n        <= 1'b1;
      write_strobe_n       <= 1'b1;
      output_strobe_n      <= 1'b1;
      nonvolatile_strobe_n <= 1'b1;
      data_oe              <= 1'b0;
      case (next_state)
        S_WR: begin
          chip_select_n  <= 1'b0;
          write_strobe_n <= 1'b0;
          data_oe        <= 1'b1;                   // Device floated
        end
        S_RD: begin
          chip_select_n   <= 1'b0;
          output_strobe_n <= 1'b0;
        end
        S_SOFF: chip_select_n <= 1'b0;              // Output strobe high
        S_STP: begin
          chip_select_n        <= 1'b0;
          write_strobe_n       <= 1'b0;
          nonvolatile_strobe_n <= 1'b0;             // Device floats
        end
        S_RCP: begin
          chip_select_n        <= 1'b0;
          output_strobe_n      <= 1'b0;
          nonvolatile_strobe_n <= 1'b0;
        end
        default: ;
      endcase
      if (state == S_IDLE && next_state != S_IDLE) begin
        mem_addr <= addr;
        data_out <= wdata;
      end
      if (state == S_RD && t_done)
        rdata <= din_sync;
      // Ack once the whole operation including recovery is over
      if (state == S_BUSY && t_done)
        ack <= 1'b1;
    end
  end
endmodule // shadow_ram_host

//--- src/wait_timer.v
/*
  Down-counting wait timer with load and done pulse.
  Assumes loads come from logic on the same clock.
*/
`timescale 1ns/1ps
module wait_timer #(
  parameter W = 24
) (
  input  wire         clk,   // Controller clock
  input  wire         srst,  // Sync reset, high
  input  wire         ce,    // Clock enable
  input  wire         load,  // Load a new count
  input  wire [W-1:0] count, // Cycles to wait
  output reg          busy,  // Count running
  output wire         done   // Count at last cycle
);
  reg [W-1:0] remain;

  // --------------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------------
  assign done = busy && (remain == {{(W-1){1'b0}}, 1'b1});

  // Load wins over a running count
  always @(posedge clk) begin
    if (srst) begin
      remain <= {W{1'b0}};
      busy   <= 1'b0;
    end else if (ce) begin
      if (load) begin
        remain <= count;
        busy   <= (count != {W{1'b0}});
      end else if (busy) begin
        remain <= remain - {{(W-1){1'b0}}, 1'b1};
        busy   <= (remain != {{(W-1){1'b0}}, 1'b1});
      end
    end
  end
endmodule // wait_timer

//--- verification/shadow_ram_device_model.sv
/* Behavioural model of the shadowed RAM seen at the pins.
   Assumes it samples the host pins on the host clock. */
`timescale 1ns/1ps
// ----------------------------------------
// Memory model
// ----------------------------------------
module shadow_ram_device_model #(
  parameter STORE_CYC = 30, // Store busy cycles
  parameter PU_RAM    = 10, // Power-up RAM lockout
  parameter PU_NV     = 20  // Power-up nv lockout
) (
  input  wire logic       clk,  // Host clock
  input  wire logic       srst, // Power-up stand-in
  input  wire logic [8:0] a,    // Address pins
  input  wire logic       cs_n, // Select
  input  wire logic       we_n, // Write
  input  wire logic       oe_n, // Output
  input  wire logic       nv_n, // Nonvolatile
  input  wire logic [7:0] dh,   // Host data
  input  wire logic       doe,  // Host drives
  output logic      [7:0] din   // Resolved data wire
);
  logic [7:0] ram [0:511];
  logic [7:0] nv [0:511];
  logic [7:0] last;
  int         sc, rc, busy, pu;
  wire        sel = !cs_n && !nv_n && busy == 0 && pu >= PU_NV;
  wire        rd  = !cs_n && !oe_n && we_n && nv_n && pu >= PU_RAM;
  // Released wire toggles so a stale value never passes
  always_comb din = rd ? ram[a] : (doe ? dh : ~last);
  // Writes, pulse counting and array copies
  always @(posedge clk) begin
    last <= srst ? 8'h00 : din;
    if (!cs_n && !we_n && nv_n && doe && pu >= PU_RAM) ram[a] <= dh;
    if (srst) begin
      pu <= 0; busy <= 0; sc <= 0; rc <= 0;
    end else begin
      if (pu < PU_NV) pu <= pu + 1;
      if (busy > 0) busy <= busy - 1;
      sc <= (sel && !we_n && oe_n) ? sc + 1 : 0;
      rc <= (sel && !oe_n && we_n) ? rc + 1 : 0;
      if (sc >= 4 && !(sel && !we_n)) begin
        for (int i = 0; i < 512; i++) nv[i] <= ram[i];
        busy <= STORE_CYC;
      end
      if (rc >= 4 && rc <= 40 && !(sel && !oe_n))
        for (int i = 0; i < 512; i++) ram[i] <= nv[i];
    end
  end
endmodule // shadow_ram_device_model

//--- verification/shadow_ram_host_assertions.sv
/* Pin-sequence checks for the shadow RAM host controller.
   Assumes the top ports only, one clock, sync reset srst. */
`timescale 1ns/1ps
// ----------------------------------------
// Checker
// ----------------------------------------
module shadow_ram_host_checker (
  input wire logic clk,                  // Controller clock
  input wire logic srst,                 // Sync reset
  input wire logic ce,                   // Clock enable
  input wire logic ram_ready,            // RAM access allowed
  input wire logic nv_ready,             // Store/recall allowed
  input wire logic chip_select_n,        // Select pin
  input wire logic write_strobe_n,       // Write pin
  input wire logic output_strobe_n,      // Output pin
  input wire logic nonvolatile_strobe_n, // Nonvolatile pin
  input wire logic data_oe               // Host drives data
);
  default clocking cb @(posedge clk); endclocking
  // A frozen controller stretches every phase, so checks rest while ce is low
  default disable iff (srst || !ce);
  // Six cycles cover the 150 ns select width
  a_write_cs_width: assert property ($fell(write_strobe_n) && nonvolatile_strobe_n |->
    (!chip_select_n && !write_strobe_n && data_oe)[*6] ##1 write_strobe_n)
    else $error("write select too short");
  a_store_pulse_len: assert property ($fell(nonvolatile_strobe_n) && !write_strobe_n |->
    (!chip_select_n && !write_strobe_n && !nonvolatile_strobe_n)[*4])
    else $error("store pulse too short");
  a_store_oe_off: assert property ($fell(nonvolatile_strobe_n) && !write_strobe_n |->
    output_strobe_n && $past(output_strobe_n)) else $error("output strobe low at store");
  a_recall_window: assert property ($fell(nonvolatile_strobe_n) && !output_strobe_n |->
    (!chip_select_n && !output_strobe_n && !nonvolatile_strobe_n)[*4] ##[1:36]
    nonvolatile_strobe_n) else $error("recall pulse outside window");
  a_store_hold_off: assert property ($rose(nonvolatile_strobe_n) && !$past(write_strobe_n) |=>
    nonvolatile_strobe_n[*8]) else $error("request during store");
  a_ram_gate: assert property (!ram_ready |-> chip_select_n)
    else $error("select before ram ready");
  a_nv_gate: assert property (!nv_ready |-> nonvolatile_strobe_n)
    else $error("nv strobe before nv ready");
  a_no_bus_fight: assert property (data_oe |-> output_strobe_n)
    else $error("host drives while memory may drive");
  c_store: cover property ($fell(nonvolatile_strobe_n) && !write_strobe_n);
  c_recall: cover property ($fell(nonvolatile_strobe_n) && !output_strobe_n);
  c_write: cover property ($fell(write_strobe_n) && nonvolatile_strobe_n);
endmodule // shadow_ram_host_checker
bind shadow_ram_host shadow_ram_host_checker u_chk (.clk(clk), .srst(srst), .ce(ce),
  .ram_ready(ram_ready), .nv_ready(nv_ready), .chip_select_n(chip_select_n),
  .write_strobe_n(write_strobe_n), .output_strobe_n(output_strobe_n),
  .nonvolatile_strobe_n(nonvolatile_strobe_n), .data_oe(data_oe));

//--- verification/shadow_ram_host_tb_top.sv
/* Self-checking bench: host controller against the memory model.
   Assumes short power-up and store counts set by parameter. */
`timescale 1ns/1ps
`include "shadow_ram_consts.vh"
// ----------------------------------------
// Bench top
// ----------------------------------------
module shadow_ram_host_tb_top;
  logic clk = 0, srst = 1, ce = 1, req = 0;
  logic [1:0] op = 0;
  logic [8:0] addr = 0;
  logic [7:0] wdata = 0;
  wire        ready, ack, ram_ready, nv_ready, chip_select_n, write_strobe_n;
  wire        output_strobe_n, nonvolatile_strobe_n, data_oe;
  wire  [8:0] mem_addr;
  wire  [7:0] rdata, data_in, data_out;
  int         miscompares = 0, n_compared = 0;
  always #12.5 clk = ~clk;
  shadow_ram_host #(.POWERUP_RAM(10), .POWERUP_NV(20), .STORE_CYCLE(30)) dut (.clk(clk),
    .srst(srst), .ce(ce), .req(req), .op(op), .addr(addr), .wdata(wdata), .ready(ready),
    .ack(ack), .rdata(rdata), .ram_ready(ram_ready), .nv_ready(nv_ready),
    .mem_addr(mem_addr), .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
    .output_strobe_n(output_strobe_n), .nonvolatile_strobe_n(nonvolatile_strobe_n),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
  shadow_ram_device_model #(.STORE_CYC(30), .PU_NV(20), .PU_RAM(10)) mem (.clk(clk),
    .srst(srst), .a(mem_addr), .cs_n(chip_select_n), .we_n(write_strobe_n),
    .oe_n(output_strobe_n),
    .nv_n(nonvolatile_strobe_n), .dh(data_out), .doe(data_oe), .din(data_in));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Request held from a falling edge until the taking edge
  task automatic run_op(input logic [1:0] c, input logic [8:0] a, input logic [7:0] d);
    int n;
    @(negedge clk);
    req = 1; op = c; addr = a; wdata = d;
    #1;
    for (n = 0; n < 100 && ready !== 1'b1; n++) @(negedge clk);
    check(8'(n < 100), 8'h01);
    @(negedge clk);
    req = 0;
    // Ack stands one cycle; looked at on falling edges where it is settled
    for (n = 0; n < 400 && ack !== 1'b1; n++) @(negedge clk);
    check(8'(n < 400), 8'h01);
  endtask
  task automatic test_powerup;
    int n;
    for (n = 0; n < 100 && ram_ready !== 1'b1; n++) @(negedge clk);
    check({7'h0, nv_ready}, 8'h00);
    check({7'h0, chip_select_n}, 8'h01);
    op = `OP_STORE;
    #1;
    check({7'h0, ready}, 8'h00);
    op = `OP_WRITE;
    #1;
    check({7'h0, ready}, 8'h01);
    for (n = 0; n < 100 && nv_ready !== 1'b1; n++) @(negedge clk);
    check({7'h0, nv_ready}, 8'h01);
    $display("powerup done");
  endtask
  // Back-to-back writes at both address ends, then read back
  task automatic test_write_read;
    run_op(`OP_WRITE, 9'h000, 8'hA5);
    run_op(`OP_WRITE, 9'h1FF, 8'h5A);
    run_op(`OP_READ, 9'h000, 8'h00);
    check(rdata, 8'hA5);
    run_op(`OP_READ, 9'h1FF, 8'h00);
    check(rdata, 8'h5A);
    $display("write_read done");
  endtask
  // Clock enable low mid-write: pins hold, then the write finishes late
  task automatic test_freeze;
    int n;
    @(negedge clk);
    req = 1; op = `OP_WRITE; addr = 9'h020; wdata = 8'h66;
    @(negedge clk);
    req = 0;
    ce = 0;
    repeat (10) @(negedge clk);
    check({7'h0, chip_select_n}, 8'h00);
    check({7'h0, write_strobe_n}, 8'h00);
    ce = 1;
    for (n = 0; n < 20 && ack !== 1'b1; n++) @(negedge clk);
    check(8'(n), 8'(`WRITE_CS_CYC + 1));
    run_op(`OP_READ, 9'h020, 8'h00);
    check(rdata, 8'h66);
    $display("freeze done");
  endtask
  // Store, spoil RAM and read it, recall, then read back both stored bytes
  task automatic test_store_recall;
    run_op(`OP_WRITE, 9'h010, 8'h3C);
    run_op(`OP_STORE, 9'h000, 8'h00);
    run_op(`OP_WRITE, 9'h010, 8'hC3);
    run_op(`OP_READ, 9'h010, 8'h00);
    check(rdata, 8'hC3);
    run_op(`OP_RECALL, 9'h000, 8'h00);
    run_op(`OP_READ, 9'h010, 8'h00);
    check(rdata, 8'h3C);
    run_op(`OP_READ, 9'h1FF, 8'h00);
    check(rdata, 8'h5A);
    $display("store_recall done");
  endtask
  initial begin
    repeat (12) @(negedge clk);
    srst = 0;
    test_powerup();
    test_write_read();
    test_freeze();
    test_store_recall();
    stop_test();
  end
  // Watchdog well beyond the few hundred cycles expected
  initial begin
    #100us;
    miscompares++;
    stop_test();
  end
endmodule // shadow_ram_host_tb_top
